// [tcc_channels.sv]
/*
  Six-channel capture/compare/PWM logic with byte-wide register port.
  Assumes pins are synchronous to clk_sys and software keeps the
  documented access order for coherent 16-bit values.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// What this block does
// - capture mode sets the flag on the selected pin edge.
// - compare mode sets the flag when counter equals channel value.
// - flag clears by read-while-set then write zero; new event cancels.
// - writing one to the flag does nothing; reset clears it.
// - channel interrupt request only while its enable bit is one.
// - even channels own buffered bit; it disables odd partner and pin.
// - buffered bit with nonzero edge field gives buffered compare/PWM.
// - unbuffered: low mode bit picks capture (0) or compare (1).
// - edge field 00: low mode bit presets output, 1 low, 0 high.
// - edge field 00 leaves pin to port; held state drives when on.
// - capture edge: 01 rising, 10 falling, 11 both.
// - compare match action: 01 toggle, 10 low, 11 high.
// - toggle-on-wrap toggles compare output at wrap; no capture effect.
// - wrap action beats compare match in the same cycle.
// - full-duty force with toggle-on-wrap set gives 100% duty from the next period.
// - value register holds captured count or compare value.
// - high byte read blocks captures until low byte read.
// - high byte write blocks matches and flag until low byte written.
// - reset clears mode and edge bits, disconnecting every pin.
// - counter wraps at modulo and restarts from zero.
// - counter halt stops counting and inhibits captures.
module tcc_channels #(
  parameter int CHANNELS = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // channel pins
  input wire logic [CHANNELS-1:0] pin_in,
  output logic [CHANNELS-1:0] pin_out,
  output logic [CHANNELS-1:0] pin_oe,
  // interrupt requests, one per channel
  output logic [CHANNELS-1:0] ch_irq
);
  import tcc_pkg::*;

  // address map and even/odd pairing are laid out for six channels
  if (CHANNELS != NUM_CH || CHANNELS % 2 != 0) begin : g_bad_channels
    $error("tcc_channels: CHANNELS must be 6");
  end

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [CHANNELS-1:0][7:0] ctrl;
    logic [CHANNELS-1:0][15:0] value;
    logic [CHANNELS-1:0] armed; // flag seen set by a read
    logic [CHANNELS-1:0] cap_lock;
    logic [CHANNELS-1:0] cmp_lock;
    logic [CHANNELS-1:0][7:0] wr_hold;
    logic [CHANNELS-1:0] out_lvl;
    logic [CHANNELS-1:0] max_act;
    logic [CHANNELS-1:0] buf_sel; // odd partner active in buffered mode
    logic [7:0] tctrl;
    logic [15:0] modulo;
    logic [7:0] mod_hold;
    logic [7:0] cnt_lo_latch;
    logic [7:0] rdata;
    logic [CHANNELS-1:0] pout;
    logic [CHANNELS-1:0] poe;
    logic [CHANNELS-1:0] irq;
  } blk_state_t;

  blk_state_t st, next_st;
  logic rst_n;
  logic [15:0] count;
  logic wrap;
  logic [CHANNELS-1:0] edge_hit;

  assign rst_n = st.rst_sync[1];

  tcc_counter u_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .halt(st.tctrl[BIT_HALT]),
    .clear(st.tctrl[BIT_CLR]),
    .modulo(st.modulo),
    .count(count),
    .wrap(wrap)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_edge
      tcc_edge u_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(pin_in[g]),
        .sel(st.ctrl[g][BIT_ELSB:BIT_ELSA]),
        .hit(edge_hit[g])
      );
    end
  endgenerate

  // true when odd channel c is taken over by its even partner
  function automatic logic partner_buf(input blk_state_t s, input int c);
    return (c % 2 == 1) && s.ctrl[c-1][BIT_MSB];
  endfunction : partner_buf

  always_comb begin
    int ch;
    int base;
    ch_mode_t md;
    logic ev;
    logic match;
    logic [15:0] cmpv;
    logic [1:0] el;
    logic acc;
    logic [1:0] off;
    ch = 0;
    base = 0;
    md = CH_OFF;
    ev = 1'b0;
    match = 1'b0;
    cmpv = 16'h0000;
    el = 2'h0;
    acc = 1'b0;
    off = 2'h0;
    next_st = st;
    next_st.rst_sync = {st.rst_sync[0], 1'b1};
    next_st.rdata = 8'h00;
    next_st.tctrl[BIT_CLR] = 1'b0; // clear is a one-shot

    // counter-side registers
    if (reg_wr && reg_addr == ADDR_TCTRL) next_st.tctrl = reg_wdata;
    if (reg_wr && reg_addr == ADDR_MOD_H) next_st.mod_hold = reg_wdata;
    if (reg_wr && reg_addr == ADDR_MOD_L)
      next_st.modulo = {st.mod_hold, reg_wdata};
    if (reg_rd && reg_addr == ADDR_TCTRL) next_st.rdata = st.tctrl;
    if (reg_rd && reg_addr == ADDR_MOD_H) next_st.rdata = st.modulo[15:8];
    if (reg_rd && reg_addr == ADDR_MOD_L) next_st.rdata = st.modulo[7:0];
    if (reg_rd && reg_addr == ADDR_CNT_H) begin
      next_st.rdata = count[15:8];
      next_st.cnt_lo_latch = count[7:0];
    end
    if (reg_rd && reg_addr == ADDR_CNT_L) next_st.rdata = st.cnt_lo_latch;

    for (ch = 0; ch < CHANNELS; ch++) begin
      base = ch * 3;
      acc = (reg_addr >= base[ADDR_W-1:0]) &&
            (reg_addr < base[ADDR_W-1:0] + CH_STRIDE);
      off = 2'(reg_addr - base[ADDR_W-1:0]);
      md = decode_mode(st.ctrl[ch], (ch % 2) == 0);
      el = st.ctrl[ch][BIT_ELSB:BIT_ELSA];
      if (partner_buf(st, ch)) md = CH_OFF;

      // events
      ev = 1'b0;
      if (md == CH_CAPTURE && edge_hit[ch] && !st.cap_lock[ch] &&
          !st.tctrl[BIT_HALT]) begin
        ev = 1'b1;
        next_st.value[ch] = count;
      end
      cmpv = st.value[ch];
      if (md == CH_BUFFERED && st.buf_sel[ch])
        cmpv = st.value[ch+1];
      match = (md == CH_COMPARE || md == CH_BUFFERED) &&
              !st.cmp_lock[ch] && count == cmpv;
      if (match) ev = 1'b1;

      // output level
      if (md == CH_OFF && el == EL_OFF)
        next_st.out_lvl[ch] = ~st.ctrl[ch][BIT_MSA];
      if (md == CH_COMPARE || md == CH_BUFFERED) begin
        if (wrap) begin
          next_st.max_act[ch] = st.ctrl[ch][BIT_MAX];
          if (md == CH_BUFFERED) next_st.buf_sel[ch] = ~st.buf_sel[ch];
        end
        if (wrap && st.ctrl[ch][BIT_TOV]) begin
          next_st.out_lvl[ch] = ~st.out_lvl[ch];
        end else if (match) begin
          case (el)
            EL_TOGGLE: next_st.out_lvl[ch] = ~st.out_lvl[ch];
            EL_LOW: next_st.out_lvl[ch] = 1'b0;
            EL_HIGH: next_st.out_lvl[ch] = 1'b1;
            default: next_st.out_lvl[ch] = st.out_lvl[ch];
          endcase
        end
      end else begin
        next_st.max_act[ch] = 1'b0;
        next_st.buf_sel[ch] = 1'b0;
      end

      // register reads
      if (reg_rd && acc && !partner_buf(st, ch)) begin
        case (off)
          OFF_CTRL: begin
            next_st.rdata = st.ctrl[ch];
            if (st.ctrl[ch][BIT_FLAG]) next_st.armed[ch] = 1'b1;
          end
          OFF_VAL_H: begin
            next_st.rdata = st.value[ch][15:8];
            if (md == CH_CAPTURE) next_st.cap_lock[ch] = 1'b1;
          end
          OFF_VAL_L: begin
            next_st.rdata = st.value[ch][7:0];
            next_st.cap_lock[ch] = 1'b0;
          end
          default: next_st.rdata = 8'h00;
        endcase
      end

      // register writes; odd value stays writable as the buffer half
      if (reg_wr && acc) begin
        case (off)
          OFF_CTRL: begin
            if (!partner_buf(st, ch)) begin
              next_st.ctrl[ch][6:0] = reg_wdata[6:0];
              if (ch % 2 == 1) next_st.ctrl[ch][BIT_MSB] = 1'b0;
              if (!reg_wdata[BIT_FLAG] && st.armed[ch])
                next_st.ctrl[ch][BIT_FLAG] = 1'b0;
              next_st.armed[ch] = 1'b0;
            end
          end
          OFF_VAL_H: begin
            next_st.wr_hold[ch] = reg_wdata;
            if (md != CH_CAPTURE) next_st.cmp_lock[ch] = 1'b1;
          end
          OFF_VAL_L: begin
            next_st.value[ch] = {st.wr_hold[ch], reg_wdata};
            next_st.cmp_lock[ch] = 1'b0;
          end
          default: next_st.cmp_lock[ch] = st.cmp_lock[ch];
        endcase
      end

      // set wins over clear; a fresh event also disarms the clear
      if (ev) begin
        next_st.ctrl[ch][BIT_FLAG] = 1'b1;
        next_st.armed[ch] = 1'b0;
      end

      // pins
      next_st.poe[ch] = (md == CH_COMPARE || md == CH_BUFFERED);
      next_st.pout[ch] = (st.max_act[ch] && st.ctrl[ch][BIT_TOV]) ?
                         1'b1 : next_st.out_lvl[ch];
      next_st.irq[ch] = next_st.ctrl[ch][BIT_FLAG] &&
                        next_st.ctrl[ch][BIT_IE] &&
                        !partner_buf(next_st, ch);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.tctrl <= TCTRL_RST;
      st.modulo <= MOD_RST;
    end else if (!st.rst_sync[1]) begin
      st <= '0;
      st.rst_sync <= next_st.rst_sync;
      st.tctrl <= TCTRL_RST;
      st.modulo <= MOD_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign pin_out = st.pout;
  assign pin_oe = st.poe;
  assign ch_irq = st.irq;
endmodule : tcc_channels

// [tcc_pkg.sv]
/*
  Constants and types shared by the timer channel capture/compare block.
  Assumes a byte-wide register port with one register per address.
*/
package tcc_pkg;
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 5;
  // per channel: ctrl at base, value high at base+1, value low at base+2
  localparam logic [ADDR_W-1:0] CH_STRIDE = 5'h03;
  localparam logic [1:0] OFF_CTRL = 2'h0;
  localparam logic [1:0] OFF_VAL_H = 2'h1;
  localparam logic [1:0] OFF_VAL_L = 2'h2;
  // counter-side registers (control, modulo, count), after the channels
  localparam logic [ADDR_W-1:0] ADDR_TCTRL = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_MOD_H = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_MOD_L = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_CNT_H = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_CNT_L = 5'h16;
  // channel control bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_MSB = 5;
  localparam int BIT_MSA = 4;
  localparam int BIT_ELSB = 3;
  localparam int BIT_ELSA = 2;
  localparam int BIT_TOV = 1;
  localparam int BIT_MAX = 0;
  // timer control bit positions
  localparam int BIT_HALT = 5;
  localparam int BIT_CLR = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TCTRL_RST = 8'h20;
  localparam logic [15:0] MOD_RST = 16'hffff;
  localparam logic [1:0] EL_OFF = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_LOW = 2'h2;
  localparam logic [1:0] EL_HIGH = 2'h3;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_CAPTURE = 2'b01,
    CH_COMPARE = 2'b10,
    CH_BUFFERED = 2'b11
  } ch_mode_t;

  function automatic ch_mode_t decode_mode(input logic [7:0] c,
                                           input logic has_buf);
    if (c[BIT_ELSB:BIT_ELSA] == EL_OFF) return CH_OFF;
    else if (has_buf && c[BIT_MSB]) return CH_BUFFERED;
    else if (c[BIT_MSA]) return CH_COMPARE;
    else return CH_CAPTURE;
  endfunction : decode_mode
endpackage : tcc_pkg

// [tcc_counter.sv]
/*
  Shared free-running counter with modulo wrap, halt and clear.
  Assumes the control bits come from registers in the parent.
*/
`timescale 1ns/1ps
module tcc_counter (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic halt,
  input wire logic clear,
  input wire logic [15:0] modulo,
  // status
  output logic [15:0] count,
  output logic wrap
);
  import tcc_pkg::*;
  typedef struct packed {
    logic [15:0] count;
  } cnt_state_t;
  cnt_state_t st, next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.count = 16'h0000;
    end else if (!halt) begin
      if (st.count == modulo) begin
        next_st.count = 16'h0000;
      end else begin
        next_st.count = st.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

  assign count = st.count;
  // overflow marks the cycle the count sits at modulo, so a match on
  // the same value meets it in one cycle and can lose to it
  assign wrap = !clear && !halt && (st.count == modulo);
endmodule : tcc_counter

// [tcc_edge.sv]
/*
  Edge detector for one capture pin.
  Assumes the pin input is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module tcc_edge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin and selection
  input wire logic pin,
  input wire logic [1:0] sel,
  // result
  output logic hit
);
  import tcc_pkg::*;
  typedef struct packed {
    logic prev;
  } edge_state_t;
  edge_state_t st, next_st;

  always_comb begin
    next_st.prev = pin;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end

  assign hit = (sel[0] & pin & ~st.prev) | (sel[1] & ~pin & st.prev);
endmodule : tcc_edge

// [tcc_channels_chk.sv]
/* Checker for the channel block: register read data, pins and irqs.
   Sees only the top ports; bound to tcc_channels after endmodule. */
`timescale 1ns/1ps
module tcc_channels_chk #(
  parameter int CHANNELS = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and requests
  input wire logic [CHANNELS-1:0] pin_in,
  input wire logic [CHANNELS-1:0] pin_out,
  input wire logic [CHANNELS-1:0] pin_oe,
  input wire logic [CHANNELS-1:0] ch_irq
);
  import tcc_pkg::*;
  logic no_wr;
  // until the first write every channel register and the timer control must read their reset values
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      no_wr <= 1'b1;
    else if (reg_wr)
      no_wr <= 1'b0;
  end
  property p_rd_idle;
    @(posedge clk_sys) disable iff (!rstn) !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr > ADDR_CNT_L |=> reg_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped address read not zero");
  property p_rst_ctrl;
    @(posedge clk_sys) disable iff (!rstn)
      no_wr && reg_rd && reg_addr < ADDR_TCTRL |=> reg_rdata == 8'h00;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl)
    else $error("channel register not clear after reset");
  property p_rst_halt;
    @(posedge clk_sys) disable iff (!rstn)
      no_wr && reg_rd && reg_addr == ADDR_TCTRL |=> reg_rdata == TCTRL_RST;
  endproperty
  a_rst_halt: assert property (p_rst_halt)
    else $error("counter not halted after reset");
  property p_odd_nobuf;
    @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr inside {5'h03, 5'h09, 5'h0f} |=> !reg_rdata[BIT_MSB];
  endproperty
  a_odd_nobuf: assert property (p_odd_nobuf)
    else $error("odd channel shows a buffered bit");
  property p_oe_cause;
    @(posedge clk_sys) disable iff (!rstn) pin_oe != $past(pin_oe)
      |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin enable moved without a register write");
  property p_irq_fall;
    @(posedge clk_sys) disable iff (!rstn) |($past(ch_irq) & ~ch_irq)
      |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt request dropped without a write");
  property p_rst_quiet;
    @(posedge clk_sys) disable iff (!rstn)
      $rose(rstn) |-> (pin_oe == '0 && ch_irq == '0) [*2];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("pins or irqs active right after reset");
endmodule : tcc_channels_chk
bind tcc_channels tcc_channels_chk #(.CHANNELS(CHANNELS)) tcc_channels_chk_i (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .ch_irq(ch_irq));

// [pin_partner.sv]
/* Outside circuit on the channel pins.
   Assumes the bench sets the external levels and keeps them steady. */
`timescale 1ns/1ps
module pin_partner #(
  parameter int N = 6
) (
  // level the outside circuit drives
  input wire logic [N-1:0] ext_lvl,
  // block side
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_in
);
  // outside driver yields while the block drives the pin
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : pin_partner

// [test_tcc_channels.sv]
/* Self-checking bench for tcc_channels over its register port.
   Assumes the pin model loops driven pins back to pin_in. */
`timescale 1ns/1ps
module test_tcc_channels;
  import tcc_pkg::*;
  logic clk_sys, rstn, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, m, lvl;
  logic [5:0] ext_lvl, pin_in, pin_out, pin_oe, ch_irq;
  int num_errors, checks_done, cycles;
  tcc_channels #(.CHANNELS(6)) tcc_channels_i (.clk_sys(clk_sys),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ch_irq(ch_irq));
  pin_partner #(.N(6)) pin_partner_i (.ext_lvl(ext_lvl),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("BAD run_length expected 20000 seen 20000");
      summarize();
    end
  end
  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp("reg_rdata", exp, reg_rdata);
  endtask : rd
  // looks only off the edge, after the flops have settled
  task automatic irq_chk(input int i, input logic exp, input int lim);
    #1;
    for (int n = 0; n < lim && ch_irq[i] !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    cmp("ch_irq", {7'h00, exp}, {7'h00, ch_irq[i]});
  endtask : irq_chk
  // pin levels move on a rising edge, like every other input
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    ext_lvl[0] <= v;
  endtask : set_pin
  // halt and clear around every mode change
  task automatic setmode(input int c, input logic [7:0] v);
    wr(ADDR_TCTRL, 8'h30);
    wr(5'(3 * c), v);
    wr(ADDR_TCTRL, 8'h00);
    #1;
  endtask : setmode
  task automatic clr(input int c, input logic [7:0] v);
    rd(5'(3 * c), v | 8'h80);
    wr(5'(3 * c), v);
    irq_chk(c, 1'b0, 4);
  endtask : clr
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, ext_lvl} = '0;
    {num_errors, checks_done, cycles} = '0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(5'h00, 8'h00);
    rd(ADDR_TCTRL, TCTRL_RST);
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'h00);
    for (int s = 1; s < 4; s++) begin
      m = 8'h40 | 8'(s << 2);
      setmode(0, m);
      cmp("pin_oe", 8'h00, {7'h00, pin_oe[0]});
      set_pin(1'b1);
      irq_chk(0, s != 2, 10);
      if (s != 2) begin
        wr(5'h00, m);
        irq_chk(0, 1'b1, 4);
        clr(0, m);
        wr(5'h00, m | 8'h80);
        irq_chk(0, 1'b0, 4);
      end
      set_pin(1'b0);
      irq_chk(0, s != 1, 10);
      if (s != 1) clr(0, m);
    end
    wr(ADDR_TCTRL, 8'h20);
    set_pin(1'b1);
    irq_chk(0, 1'b0, 10);
    setmode(0, 8'h0c);
    set_pin(1'b0);
    irq_chk(0, 1'b0, 10);
    rd(5'h00, 8'h8c);
    wr(5'h00, 8'h0c);
    wr(5'h01, 8'h00);
    wr(5'h02, 8'h00);
    rd(5'h01, 8'h00);
    set_pin(1'b1);
    rd(5'h00, 8'h0c);
    rd(5'h02, 8'h00);
    set_pin(1'b0);
    rd(5'h00, 8'h8c);
    for (int s = 1; s < 4; s++) begin
      m = 8'h50 | 8'(s << 2);
      setmode(2, s == 3 ? 8'h10 : 8'h00);
      cmp("pin_oe", 8'h00, {7'h00, pin_oe[2]});
      wr(5'h07, 8'h00);
      wr(5'h08, 8'h40);
      setmode(2, m);
      cmp("pin_out", {7'h00, s != 3}, {7'h00, pin_out[2]});
      irq_chk(2, 1'b1, 200);
      cmp("pin_out", {7'h00, s == 3}, {7'h00, pin_out[2]});
      clr(2, m);
    end
    setmode(2, m);
    wr(5'h07, 8'h00);
    irq_chk(2, 1'b0, 120);
    wr(5'h08, 8'h40);
    setmode(2, m);
    irq_chk(2, 1'b1, 200);
    wr(ADDR_TCTRL, 8'h30);
    wr(ADDR_MOD_H, 8'h00);
    wr(ADDR_MOD_L, 8'h10);
    wr(5'h0d, 8'h00);
    wr(5'h0e, 8'h10);
    setmode(4, 8'h1a);
    lvl = {7'h00, pin_out[4]};
    for (int k = 0; k < 2; k++) begin
      repeat (17) @(posedge clk_sys);
      #1;
      lvl = ~lvl;
      cmp("pin_out", {7'h00, lvl[0]}, {7'h00, pin_out[4]});
    end
    wr(5'h0c, 8'h1b);
    // the force waits for the next period
    repeat (40) @(posedge clk_sys);
    #1;
    cmp("pin_out", 8'h01, {7'h00, pin_out[4]});
    repeat (9) @(posedge clk_sys);
    #1;
    cmp("pin_out", 8'h01, {7'h00, pin_out[4]});
    wr(5'h03, 8'h20);
    rd(5'h03, 8'h00);
    wr(5'h01, 8'h00);
    wr(5'h02, 8'h04);
    wr(5'h04, 8'h00);
    wr(5'h05, 8'h0c);
    rd(5'h05, 8'h0c);
    setmode(0, 8'h24);
    // even register rules the first period, odd partner the second
    lvl = {7'h00, pin_out[0]};
    repeat (9) @(posedge clk_sys);
    #1;
    cmp("pin_out", {7'h00, ~lvl[0]}, {7'h00, pin_out[0]});
    repeat (17) @(posedge clk_sys);
    #1;
    cmp("pin_out", {7'h00, ~lvl[0]}, {7'h00, pin_out[0]});
    repeat (8) @(posedge clk_sys);
    #1;
    cmp("pin_out", {7'h00, lvl[0]}, {7'h00, pin_out[0]});
    wr(5'h03, 8'h54);
    rd(5'h03, 8'h00);
    cmp("pin_oe", 8'h01, {6'h00, pin_oe[1:0]});
    summarize();
  end
endmodule : test_tcc_channels
